// >>> core/fid_map.svh
// constants for the identifier readout block: opcodes, codes, timing
// assumes a 250 MHz system clock; included by the package users
`ifndef FID_MAP_SVH
`define FID_MAP_SVH
`define FID_OP_READ_IDS 8'h90
`define FID_ADDR_PART_FIRST 8'h01
`define FID_DUMMY_BYTES 2
`define FID_CLK_MHZ 250
// power-up select delay, microseconds (least time)
`define FID_PWRUP_DELAY_US 10
`define FID_PWRUP_CYCLES (`FID_PWRUP_DELAY_US * `FID_CLK_MHZ)
`endif

// >>> core/fid_pkg.sv
// types shared by the identifier readout block
// no assumptions beyond a SystemVerilog tool
package fid_pkg;
  typedef enum logic [2:0] {
    FID_IDLE, FID_DUMMY, FID_ADDR, FID_SEND, FID_IGNORE
  } fid_state_t;
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic din;
  } fid_link_in_t;
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } fid_link_out_t;
endpackage : fid_pkg

// >>> core/fid_edge_sync.sv
// two-flop synchroniser with edge detection for the link pins
// assumes inputs are asynchronous to CLOCK
module fid_edge_sync
  import fid_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire fid_link_in_t pins,
  output fid_link_in_t synced,
  output logic sck_rise,
  output logic sck_fall
);
  fid_link_in_t meta;
  fid_link_in_t stage;
  fid_link_in_t prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 3'b100;
      stage <= 3'b100;
      prev <= 3'b100;
    end else begin
      meta <= pins;
      stage <= meta;
      prev <= stage;
    end
  end
  assign synced = stage;
  assign sck_rise = stage.sck & ~prev.sck;
  assign sck_fall = ~stage.sck & prev.sck;
endmodule : fid_edge_sync

// >>> core/fid_readout.sv
// identifier readout and power-on state for the serial flash link
// assumes link pins are asynchronous; RST_N is the internal power-on reset
`include "fid_map.svh"

module fid_readout
  import fid_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_ID = 8'ha5,  // arbitrary value
  parameter int PWRUP_CYCLES = `FID_PWRUP_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SEL_N,
  input wire logic SCK,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  output logic READY,
  output logic DEEP_SLEEP,
  output logic WRITE_ENABLE_LATCH
);
  // ************************************************************
  // synchronised pins
  // ************************************************************
  fid_link_in_t pins;
  fid_link_in_t link;
  logic sck_rise;
  logic sck_fall;
  assign pins = '{sel_n: SEL_N, sck: SCK, din: DIN};
  fid_edge_sync u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .pins(pins),
    .synced(link),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall)
  );

  // ************************************************************
  // power-up delay
  // ************************************************************
  logic [$clog2(PWRUP_CYCLES+1)-1:0] pwr_cnt;
  logic ready;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_cnt <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      pwr_cnt <= pwr_cnt + 1'b1;
      // commands before this point are ignored
      ready <= (pwr_cnt == ($bits(pwr_cnt))'(PWRUP_CYCLES - 1));
    end
  end
  assign READY = ready;
  // no deep power-down entry exists in this block; sleep stays clear
  assign DEEP_SLEEP = 1'b0;
  // no write-enable opcode decoded here, so the latch holds its reset value
  assign WRITE_ENABLE_LATCH = 1'b0;

  // ************************************************************
  // command shifter and readout
  // ************************************************************
  fid_state_t state;
  fid_state_t next_state;
  logic [7:0] shift_in;
  logic [2:0] bit_cnt;
  logic dummy_cnt;
  logic part_now;
  logic [7:0] shift_out;
  logic oe;
  wire deselect = link.sel_n;
  wire [7:0] in_byte = {shift_in[6:0], link.din};
  wire byte_done = sck_rise && (bit_cnt == 3'd7);

  // ************************************************************
  // identifier selection helpers
  // ************************************************************
  // the whole address byte is compared, so 81h still means maker first
  function automatic logic fid_part_first(input logic [7:0] adr);
    return adr == `FID_ADDR_PART_FIRST;
  endfunction : fid_part_first

  // picks the identifier that follows the one now being shown
  function automatic logic [7:0] fid_next_id(input logic showing_part);
    return showing_part ? MAKER_ID : PART_ID;
  endfunction : fid_next_id

  wire part_first = fid_part_first(in_byte);
  wire [7:0] first_id = part_first ? PART_ID : MAKER_ID;
  wire op_match = ready && (in_byte == `FID_OP_READ_IDS);

  always_comb begin
    next_state = state;
    case (state)
      FID_IDLE:
        if (byte_done) begin
          next_state = op_match ? FID_DUMMY : FID_IGNORE;
        end
      FID_DUMMY:
        if (byte_done && dummy_cnt) begin
          next_state = FID_ADDR;
        end
      FID_ADDR:
        if (byte_done) begin
          next_state = FID_SEND;
        end
      FID_SEND: next_state = FID_SEND;
      FID_IGNORE: next_state = FID_IGNORE;
      default: next_state = FID_IDLE;
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= FID_IDLE;
    end else if (deselect) begin
      state <= FID_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // input shifter
  // ************************************************************
  // deselect clears only the bit count; stale shifter bits are pushed
  // out by the next eight rises before anything decodes them
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      shift_in <= 8'h00;
      bit_cnt <= 3'd0;
    end else if (deselect) begin
      bit_cnt <= 3'd0;
    end else if (sck_rise) begin
      shift_in <= in_byte;
      bit_cnt <= bit_cnt + 3'd1;
    end
  end

  // one bit is enough: exactly two dummy bytes precede the address
  wire dummy_done = (state == FID_DUMMY) && byte_done;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dummy_cnt <= 1'b0;
    end else if (deselect) begin
      dummy_cnt <= 1'b0;
    end else if (dummy_done) begin
      dummy_cnt <= ~dummy_cnt;
    end
  end

  // output byte loads at the address byte, then reloads every eighth falling edge;
  // the first bit appears on the fall after the last address bit
  // ************************************************************
  // output shifter
  // ************************************************************
  logic [2:0] out_cnt;
  wire addr_done = (state == FID_ADDR) && byte_done;
  wire send_fall = (state == FID_SEND) && sck_fall;
  wire drive_start = send_fall && !oe;
  wire id_boundary = send_fall && oe && (out_cnt == 3'd0);
  wire bit_step = send_fall && oe && (out_cnt != 3'd0);

  // the counter wraps after bit 0, so the ninth fall reloads the next id;
  // a frame cut mid-byte simply drops the rest of that byte
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      shift_out <= 8'h00;
      out_cnt <= 3'd0;
      part_now <= 1'b0;
      oe <= 1'b0;
    end else if (deselect) begin
      oe <= 1'b0;
      out_cnt <= 3'd0;
    end else if (addr_done) begin
      shift_out <= first_id;
      part_now <= part_first;
      out_cnt <= 3'd0;
    end else if (drive_start) begin
      // bit 7 is already loaded, so the first fall only enables the pin
      oe <= 1'b1;
      out_cnt <= 3'd1;
    end else if (id_boundary) begin
      shift_out <= fid_next_id(part_now);
      part_now <= ~part_now;
      out_cnt <= 3'd1;
    end else if (bit_step) begin
      shift_out <= {shift_out[6:0], 1'b0};
      out_cnt <= out_cnt + 3'd1;
    end
  end

  // ************************************************************
  // pin outputs
  // ************************************************************
  assign DOUT = shift_out[7];
  assign DOUT_OE = oe;
endmodule : fid_readout

// >>> bench/fid_readout_asserts.sv
// port checker for the identifier readout block
// assumes it is bound onto fid_readout
module fid_readout_asserts #(
  parameter int PWRUP_CYCLES = 16
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SEL_N,
  input wire logic SCK,
  input wire logic DIN,
  input wire logic DOUT,
  input wire logic DOUT_OE,
  input wire logic READY,
  input wire logic DEEP_SLEEP,
  input wire logic WRITE_ENABLE_LATCH
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence held_low;
    (!SEL_N) [*5];
  endsequence
  a_sleep_never: assert property (!DEEP_SLEEP)
    else $error("deep sleep raised");
  a_latch_clear: assert property (!WRITE_ENABLE_LATCH)
    else $error("write latch set");
  a_ready_holds: assert property (READY |=> READY)
    else $error("ready dropped");
  a_oe_ready: assert property (!READY |-> !DOUT_OE)
    else $error("drive before ready");
  a_oe_off: assert property (SEL_N [*6] |-> !DOUT_OE)
    else $error("drive while deselected");
  a_oe_stays: assert property (held_low ##0 DOUT_OE |=> DOUT_OE)
    else $error("drive lost in frame");
  a_oe_first: assert property ($rose(DOUT_OE) |-> !SCK && !SEL_N)
    else $error("drive not on fall");
  a_dout_fall: assert property (DOUT_OE && $past(DOUT_OE) && $changed(DOUT) |-> !SCK)
    else $error("data moved off fall");
endmodule : fid_readout_asserts
bind fid_readout fid_readout_asserts #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk_u (.CLOCK, .RST_N,
  .SEL_N, .SCK, .DIN, .DOUT, .DOUT_OE, .READY, .DEEP_SLEEP, .WRITE_ENABLE_LATCH);

// >>> bench/fid_host_model.sv
// host link controller, clock mode zero, sck period 17 clk cycles
// assumes clk is the block's clock; sck stands low outside frames
module fid_host_model (
  input wire logic clk,
  input wire logic dout,
  output logic sel_n,
  output logic sck,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    din = 1'b1;
  end
  task automatic frame(input logic [31:0] req, output logic [31:0] got);
    got = 32'h0;
    @(posedge clk) sel_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      // past the request din is don't-care, so it toggles
      @(posedge clk) din <= (i < 32) ? req[31 - i] : ~din;
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      if (i >= 32) got = {got[30:0], dout};
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    sel_n <= 1'b1;
    repeat (30) @(posedge clk);
  endtask : frame
endmodule : fid_host_model

// >>> bench/fid_readout_bench.sv
// self-checking bench for the identifier readout block
// assumes the host model and the bound checker
module fid_readout_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MK = 8'h5a; // arbitrary value
  localparam logic [7:0] PT = 8'ha5; // arbitrary value
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic oe_seen = 1'b0;
  logic SEL_N, SCK, DIN, DOUT, DOUT_OE, READY, DEEP_SLEEP, WRITE_ENABLE_LATCH;
  logic [31:0] got;
  int error_cnt = 0;
  int checks_done = 0;
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (DOUT_OE === 1'b1) oe_seen <= 1'b1;
  // delay outlasts the first opcode byte, so that frame's opcode is decoded before READY rises
  fid_readout #(.MAKER_ID(MK), .PART_ID(PT), .PWRUP_CYCLES(400)) dut_u (.CLOCK, .RST_N,
    .SEL_N, .SCK, .DIN, .DOUT, .DOUT_OE, .READY, .DEEP_SLEEP, .WRITE_ENABLE_LATCH);
  fid_host_model host_u (.clk(CLOCK), .dout(DOUT), .sel_n(SEL_N), .sck(SCK), .din(DIN));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, input logic [7:0] adr);
    oe_seen = 1'b0;
    host_u.frame({op, 16'h0000, adr}, got);
    chk("oe released", {31'h0, DOUT_OE}, 32'h0);
  endtask : run
  task automatic t_power_up;
    chk("standby", {31'h0, DEEP_SLEEP}, 32'h0);
    chk("latch", {31'h0, WRITE_ENABLE_LATCH}, 32'h0);
    chk("ready early", {31'h0, READY}, 32'h0);
    run(8'h90, 8'h00);
    chk("early oe", {31'h0, oe_seen}, 32'h0);
  endtask : t_power_up
  task automatic t_ids(input logic [7:0] adr, input logic [31:0] exp);
    run(8'h90, adr);
    chk("ids", got, exp);
    chk("ready", {31'h0, READY}, 32'h1);
  endtask : t_ids
  task automatic t_refused;
    run(8'h9f, 8'h01);
    chk("refused oe", {31'h0, oe_seen}, 32'h0);
  endtask : t_refused
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_power_up;
    t_ids(8'h00, {MK, PT, MK, PT});
    t_ids(8'h01, {PT, MK, PT, MK});
    t_ids(8'h81, {MK, PT, MK, PT});
    t_refused;
    give_verdict;
  end
  initial begin
    #60000;
    error_cnt++;
    give_verdict;
  end
endmodule : fid_readout_bench
